// ==== pkg/adaptive_clock_defs.svh ====
// register offsets, field positions, reset values and timing for the adaptive clock block
`ifndef ADAPTIVE_CLOCK_DEFS_SVH
`define ADAPTIVE_CLOCK_DEFS_SVH

// byte addresses on the microcontroller data bus
`define ADDR_SOF_CLOCK_CAPTURE_HIGH 16'hffe3
`define ADDR_SOF_CLOCK_CAPTURE_LOW  16'hffe4
`define ADDR_SYNTH1_FREQ_WORD_HIGH  16'hffe5
`define ADDR_SYNTH1_FREQ_WORD_MID   16'hffe6
`define ADDR_SYNTH1_FREQ_WORD_LOW   16'hffe7

// field positions inside the frequency word and the captured count
`define FREQ_HIGH_MSB 23
`define FREQ_HIGH_LSB 16
`define FREQ_MID_MSB  15
`define FREQ_MID_LSB  8
`define FREQ_LOW_MSB  7
`define FREQ_LOW_LSB  0
`define COUNT_HIGH_MSB 15
`define COUNT_HIGH_LSB 8
`define COUNT_LOW_MSB  7
`define COUNT_LOW_LSB  0

// reset values
`define FREQ_WORD_RESET  24'h000000
`define COUNT_RESET      16'h0000
`define BYTE_RESET       8'h00

// timing: read data appear this many clock edges after the read strobe
`define READ_LATENCY_CYCLES 1

`endif

// ==== pkg/adaptive_clock_pkg.sv ====
// types shared by the adaptive clock block
`default_nettype none
package adaptive_clock_pkg;

  typedef logic [23:0] freq_word_t;
  typedef logic [15:0] frame_count_t;
  typedef logic [7:0]  reg_byte_t;

  // source of a master clock path
  typedef enum logic [1:0] {
    src_first_synth  = 2'b01,
    src_second_synth = 2'b10
  } clk_src_t;

endpackage
`default_nettype wire

// ==== logic/synth_phase_accum.sv ====
// phase accumulator that turns a frequency word into a square clock level
`timescale 1ns/1ps
`default_nettype none
module synth_phase_accum #(
  parameter int WIDTH = 24
) (
  input  wire logic             ref_clk,    // system clock
  input  wire logic             rst_b,      // async reset, active low
  input  wire logic [WIDTH-1:0] freq_word,  // phase step per clock
  output logic                  clk_level   // synthesized clock level
);

  logic [WIDTH-1:0] phase;
  logic [WIDTH-1:0] next_phase;

  // step wraps naturally, so output frequency is ref * word / 2**WIDTH
  assign next_phase = phase + freq_word;

  // accumulator and registered top bit
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase     <= '0;
      clk_level <= 1'b0;
    end else begin
      phase     <= next_phase;
      clk_level <= next_phase[WIDTH-1];
    end
  end

endmodule // synth_phase_accum
`default_nettype wire

// ==== logic/adaptive_clock_sof_capture.sv ====
// first adaptive clock synthesizer word and start-of-frame master clock capture
`include "adaptive_clock_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module adaptive_clock_sof_capture #(
  parameter int FREQ_WIDTH  = 24,
  parameter int COUNT_WIDTH = 16
) (
  input  wire logic        ref_clk,              // 100 MHz system clock
  input  wire logic        rst_b,                // async reset, active low
  input  wire logic [15:0] mem_addr,             // microcontroller data address
  input  wire logic        mem_wr,               // write strobe, one cycle
  input  wire logic        mem_rd,               // read strobe, one cycle
  input  wire logic [7:0]  mem_wdata,            // write data
  output logic      [7:0]  mem_rdata,            // read data, registered
  output logic             mem_rvalid,           // read answer pulse
  input  wire logic        sof_pulse,            // usb start of frame, one cycle
  input  wire logic        second_master_clk_out,// level from the second synthesizer
  input  wire logic        master_out_sel,       // 0 first synth, 1 second synth
  input  wire logic        count_clk_sel,        // 0 primary output, 1 second output
  output logic             codec_master_clk_out, // master clock to the codec
  output logic      [23:0] synth_freq_word       // current word to the first synth
);

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  adaptive_clock_pkg::freq_word_t   freq_word;
  adaptive_clock_pkg::frame_count_t free_count;
  adaptive_clock_pkg::frame_count_t frame_clock_count;
  adaptive_clock_pkg::reg_byte_t    next_rdata;
  adaptive_clock_pkg::clk_src_t     out_src;
  adaptive_clock_pkg::clk_src_t     cnt_src;

  logic first_synth_level;
  logic cnt_clk_level;
  logic cnt_clk_prev;
  logic cnt_clk_rise;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  wire hit_cap_high  = (mem_addr == `ADDR_SOF_CLOCK_CAPTURE_HIGH);
  wire hit_cap_low   = (mem_addr == `ADDR_SOF_CLOCK_CAPTURE_LOW);
  wire hit_freq_high = (mem_addr == `ADDR_SYNTH1_FREQ_WORD_HIGH);
  wire hit_freq_mid  = (mem_addr == `ADDR_SYNTH1_FREQ_WORD_MID);
  wire hit_freq_low  = (mem_addr == `ADDR_SYNTH1_FREQ_WORD_LOW);
  wire hit_any       = hit_cap_high | hit_cap_low | hit_freq_high
                     | hit_freq_mid | hit_freq_low;

  // write enables; capture addresses take no write
  wire wr_freq_high = mem_wr & hit_freq_high;
  wire wr_freq_mid  = mem_wr & hit_freq_mid;
  wire wr_freq_low  = mem_wr & hit_freq_low;

  ////////////////////////////////////////////////////////////////////////////
  // read data selection, unmapped addresses read zero

  assign next_rdata =
      hit_freq_high ? freq_word[`FREQ_HIGH_MSB:`FREQ_HIGH_LSB] :
      hit_freq_mid  ? freq_word[`FREQ_MID_MSB:`FREQ_MID_LSB] :
      hit_freq_low  ? freq_word[`FREQ_LOW_MSB:`FREQ_LOW_LSB] :
      hit_cap_high  ? frame_clock_count[`COUNT_HIGH_MSB:`COUNT_HIGH_LSB] :
      hit_cap_low   ? frame_clock_count[`COUNT_LOW_MSB:`COUNT_LOW_LSB] :
      `BYTE_RESET;

  // registered read answer
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_rdata  <= `BYTE_RESET;
      mem_rvalid <= 1'b0;
    end else begin
      mem_rdata  <= mem_rd ? next_rdata : `BYTE_RESET;
      mem_rvalid <= mem_rd & hit_any;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frequency word bytes

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      freq_word <= `FREQ_WORD_RESET;
    end else begin
      if (wr_freq_high) begin
        freq_word[`FREQ_HIGH_MSB:`FREQ_HIGH_LSB] <= mem_wdata;
      end
      if (wr_freq_mid) begin
        freq_word[`FREQ_MID_MSB:`FREQ_MID_LSB] <= mem_wdata;
      end
      if (wr_freq_low) begin
        freq_word[`FREQ_LOW_MSB:`FREQ_LOW_LSB] <= mem_wdata;
      end
    end
  end

  assign synth_freq_word = freq_word;

  ////////////////////////////////////////////////////////////////////////////
  // first synthesizer

  synth_phase_accum #(
    .WIDTH     (FREQ_WIDTH)
  ) u_first_synth (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .freq_word (freq_word),
    .clk_level (first_synth_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // source selection for the codec clock and the counter clock

  assign out_src = master_out_sel ? adaptive_clock_pkg::src_second_synth
                                  : adaptive_clock_pkg::src_first_synth;
  assign cnt_src = count_clk_sel  ? adaptive_clock_pkg::src_second_synth
                                  : adaptive_clock_pkg::src_first_synth;

  // codec master clock output, registered
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      codec_master_clk_out <= 1'b0;
    end else begin
      case (out_src)
        adaptive_clock_pkg::src_first_synth:  codec_master_clk_out <= first_synth_level;
        adaptive_clock_pkg::src_second_synth: codec_master_clk_out <= second_master_clk_out;
        default:                              codec_master_clk_out <= 1'b0;
      endcase
    end
  end

  // counter clock picks the primary output or the second output
  assign cnt_clk_level = (cnt_src == adaptive_clock_pkg::src_second_synth)
                       ? second_master_clk_out : codec_master_clk_out;

  assign cnt_clk_rise = cnt_clk_level & ~cnt_clk_prev;

  ////////////////////////////////////////////////////////////////////////////
  // free-running counter and frame capture

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_clk_prev      <= 1'b0;
      free_count        <= `COUNT_RESET;
      frame_clock_count <= `COUNT_RESET;
    end else begin
      cnt_clk_prev <= cnt_clk_level;
      if (cnt_clk_rise) begin
        free_count <= free_count + 16'h0001;
      end
      if (sof_pulse) begin
        frame_clock_count <= free_count;
      end
    end
  end

endmodule // adaptive_clock_sof_capture
`default_nettype wire

// ==== bench/adaptive_clock_sof_capture_checker.sv ====
// port assertions for the adaptive clock block
`timescale 1ns/1ps
`default_nettype none
`include "adaptive_clock_defs.svh"
module adaptive_clock_sof_capture_checker (
  input wire logic        ref_clk,               // clock
  input wire logic        rst_b,                 // reset
  input wire logic [15:0] mem_addr,              // address
  input wire logic        mem_wr,                // write
  input wire logic        mem_rd,                // read
  input wire logic [7:0]  mem_wdata,             // wdata
  input wire logic [7:0]  mem_rdata,             // rdata
  input wire logic        mem_rvalid,            // rvalid
  input wire logic        sof_pulse,             // frame
  input wire logic        second_master_clk_out, // clock 2
  input wire logic        master_out_sel,        // out sel
  input wire logic        count_clk_sel,         // count sel
  input wire logic        codec_master_clk_out,  // codec clk
  input wire logic [23:0] synth_freq_word        // word
);
  // mapped byte window
  wire logic hit = (mem_addr >= `ADDR_SOF_CLOCK_CAPTURE_HIGH)
                   && (mem_addr <= `ADDR_SYNTH1_FREQ_WORD_LOW);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_rd_mapped: assert property (mem_rd && hit |=> mem_rvalid)
    else $error("no read answer");
  a_rd_unmapped: assert property (mem_rd && !hit |=> !mem_rvalid && mem_rdata == 8'h00)
    else $error("unmapped read answered");
  a_rdata_idle: assert property (!mem_rd |=> mem_rdata == 8'h00)
    else $error("rdata not idle");
  a_wr_low_byte: assert property (mem_wr && mem_addr == `ADDR_SYNTH1_FREQ_WORD_LOW
    |=> synth_freq_word[7:0] == $past(mem_wdata)) else $error("low byte");
  a_wr_mid_byte: assert property (mem_wr && mem_addr == `ADDR_SYNTH1_FREQ_WORD_MID
    |=> synth_freq_word[15:8] == $past(mem_wdata)) else $error("mid byte");
  a_wr_high_byte: assert property (mem_wr && mem_addr == `ADDR_SYNTH1_FREQ_WORD_HIGH
    |=> synth_freq_word[23:16] == $past(mem_wdata)) else $error("high byte");
  a_word_hold: assert property (!mem_wr |=> $stable(synth_freq_word))
    else $error("word changed");
  a_rd_mid_word: assert property (mem_rd && mem_addr == `ADDR_SYNTH1_FREQ_WORD_MID
    |=> mem_rdata == $past(synth_freq_word[15:8])) else $error("mid read");
  a_codec_second: assert property ($past(rst_b) && master_out_sel [*2]
    |-> codec_master_clk_out == $past(second_master_clk_out)) else $error("codec src");
  // main scenarios reached
  cover property (sof_pulse);
  cover property (mem_wr && hit);
  cover property (master_out_sel && codec_master_clk_out);
endmodule // adaptive_clock_sof_capture_checker
`default_nettype wire

// ==== bench/codec_clock_model.sv ====
// codec side model: counts master clock rises
`timescale 1ns/1ps
`default_nettype none
module codec_clock_model (
  input  wire logic ref_clk, // system clock
  input  wire logic mclk,    // master clock in
  output var  int   rises    // rises seen
);
  logic last = 1'b0;
  // count each low to high step
  initial rises = 0;
  always @(posedge ref_clk) begin
    last <= mclk;
    if (mclk && !last) rises <= rises + 1;
  end
endmodule // codec_clock_model
`default_nettype wire

// ==== bench/adaptive_clock_sof_capture_tb_top.sv ====
// testbench for the adaptive clock block
`timescale 1ns/1ps
`default_nettype none
`include "adaptive_clock_defs.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin mismatches++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module adaptive_clock_sof_capture_tb_top;
  logic ref_clk = 1'b0, rst_b = 1'b0, mem_wr = 1'b0, mem_rd = 1'b0, sof_pulse = 1'b0;
  logic sclk = 1'b0, out_sel = 1'b0, cnt_sel = 1'b0, mem_rvalid, codec_clk, rvalid_seen;
  logic [15:0] mem_addr = 16'h0000;
  logic [7:0]  mem_wdata = 8'h00, mem_rdata;
  logic [23:0] word;
  int          mismatches = 0, checked = 0, rises;
  // clocks: system and second synth level
  always #5 ref_clk = ~ref_clk;
  always @(negedge ref_clk) sclk <= ~sclk;
  adaptive_clock_sof_capture u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .mem_addr(mem_addr),
    .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_rvalid(mem_rvalid), .sof_pulse(sof_pulse), .second_master_clk_out(sclk),
    .master_out_sel(out_sel), .count_clk_sel(cnt_sel), .codec_master_clk_out(codec_clk),
    .synth_freq_word(word));
  codec_clock_model u_codec (.ref_clk(ref_clk), .mclk(codec_clk), .rises(rises));
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (mismatches == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    mem_addr = a;
    mem_wdata = d;
    mem_wr = 1'b1;
    @(negedge ref_clk);
    mem_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    mem_addr = a;
    mem_rd = 1'b1;
    @(negedge ref_clk);
    mem_rd = 1'b0;
    d = mem_rdata;
    rvalid_seen = mem_rvalid;
  endtask
  task automatic frame;
    @(negedge ref_clk);
    sof_pulse = 1'b1;
    @(negedge ref_clk);
    sof_pulse = 1'b0;
  endtask
  // two frames 200 cycles apart; count and codec rises between them
  task automatic meas(input logic cs, os, input logic [7:0] hi, input logic [15:0] ec, eo);
    logic [15:0] c0, c1;
    int r0;
    cnt_sel = cs;
    out_sel = os;
    wr(`ADDR_SYNTH1_FREQ_WORD_HIGH, hi);
    repeat (8) @(negedge ref_clk);
    frame;
    r0 = rises;
    rd(`ADDR_SOF_CLOCK_CAPTURE_LOW, c0[7:0]);
    rd(`ADDR_SOF_CLOCK_CAPTURE_HIGH, c0[15:8]);
    repeat (194) @(negedge ref_clk);
    frame;
    `CHK("codec rises", eo, 16'(rises - r0))
    rd(`ADDR_SOF_CLOCK_CAPTURE_LOW, c1[7:0]);
    rd(`ADDR_SOF_CLOCK_CAPTURE_HIGH, c1[15:8]);
    `CHK("capture delta", ec, 16'(c1 - c0))
  endtask
  // main sequence
  initial begin
    logic [7:0] d;
    repeat (10) @(negedge ref_clk);
    rst_b = 1'b1;
    for (int a = 16'hffe3; a <= 16'hffe7; a++) begin
      rd(16'(a), d);
      `CHK("reset byte", 8'h00, d)
    end
    wr(`ADDR_SYNTH1_FREQ_WORD_HIGH, 8'ha5);
    wr(`ADDR_SYNTH1_FREQ_WORD_MID, 8'h5a);
    wr(`ADDR_SYNTH1_FREQ_WORD_LOW, 8'h3c);
    `CHK("freq word", 24'ha55a3c, word)
    rd(`ADDR_SYNTH1_FREQ_WORD_LOW, d);
    `CHK("low byte read", 8'h3c, d)
    `CHK("read rvalid", 1'b1, rvalid_seen)
    wr(`ADDR_SOF_CLOCK_CAPTURE_LOW, 8'hff);
    rd(`ADDR_SOF_CLOCK_CAPTURE_LOW, d);
    `CHK("capture write", 8'h00, d)
    rd(16'hffe8, d);
    `CHK("unmapped read", 8'h00, d)
    `CHK("unmapped rvalid", 1'b0, rvalid_seen)
    wr(`ADDR_SYNTH1_FREQ_WORD_MID, 8'h00);
    wr(`ADDR_SYNTH1_FREQ_WORD_LOW, 8'h00);
    meas(1'b0, 1'b0, 8'h80, 16'h0064, 16'h0064);
    meas(1'b0, 1'b0, 8'h00, 16'h0000, 16'h0000);
    meas(1'b1, 1'b0, 8'h00, 16'h0064, 16'h0000);
    meas(1'b0, 1'b1, 8'h00, 16'h0064, 16'h0064);
    give_verdict;
  end
  // watchdog
  initial begin
    #100000;
    mismatches++;
    give_verdict;
  end
endmodule // adaptive_clock_sof_capture_tb_top
bind adaptive_clock_sof_capture adaptive_clock_sof_capture_checker u_chk (.*);
`default_nettype wire
